// file: ssam_core_state.sv
// Core state logic: stack select control, current exception number, fixed-priority
// exception take, and the little-endian data path with region decode.
// Assumes the instruction unit drives all inputs from logic on i_ref_clk.
//
// Operation
// - Control bit 1 chooses main stack when clear, process stack when set.
// - In Handler mode the stack select bit reads zero and ignores writes.
// - Handler mode always runs on the main stack pointer.
// - Exception entry and return both update the stack select control register.
// - After reset Thread mode uses main stack until software changes it.
// - Every exception other than reset is serviced in Handler mode.
// - Core with interrupt controller prioritises exceptions and redirects program flow.
// - Data path carries 32-bit words, 16-bit halfwords and 8-bit bytes.
// - All data accesses use little-endian byte order.
// - Instruction fetches and private region accesses are always little-endian.
// - Address map is a fixed 4GB, 32-bit space that cannot move.
// - Code, SRAM, peripheral, external RAM, external device regions at fixed bases.
// - A 6-bit exception number: zero is Thread, nonzero is Handler.
`timescale 1ns/1ps
module ssam_core_state
#(
  parameter int EXC_COUNT = ssam_pkg::EXC_COUNT
)
(
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_reset,
  input  wire ssam_pkg::ssam_sreg_s   i_sreg,
  input  wire logic [EXC_COUNT-1:0]   i_exc_pend,
  input  wire logic                   i_take_en,
  input  wire ssam_pkg::ssam_ret_s    i_exc_ret,
  input  wire ssam_pkg::ssam_acc_s    i_acc,
  input  wire logic                   i_bus_rvalid,
  input  wire logic [31:0]            i_bus_rdata,
  output logic [31:0]                 o_ctrl_rdata,
  output logic                        o_use_psp,
  output logic                        o_handler,
  output logic [5:0]                  o_exc_num,
  output logic                        o_exc_take,
  output logic [5:0]                  o_exc_take_num,
  output logic                        o_entry_from_psp,
  output ssam_pkg::ssam_bus_s         o_bus,
  output logic                        o_fault,
  output logic                        o_rd_valid,
  output logic [31:0]                 o_rd_data
);

  typedef struct packed {
    logic                  spsel;
    logic [5:0]            exc_num;
    logic                  take;
    logic [5:0]            take_num;
    logic                  entry_psp;
    ssam_pkg::ssam_bus_s   bus;
    logic                  fault;
    logic [1:0]            rd_off;
    ssam_pkg::ssam_size_e  rd_size;
    logic                  rd_valid;
    logic [31:0]           rd_data;
  } ssam_state_s;

  ssam_state_s             state_ff;
  ssam_state_s             nxt_state;
  logic [6:0]              pick_w;
  logic                    handler_w;
  ssam_pkg::ssam_region_e  region_w;
  logic                    xn_w;
  logic                    core_w;
  logic                    misalign_w;
  logic                    acc_fault_w;
  logic [31:0]             shifted_w;

  // Lowest set exception number wins; bits below the first real number are ignored
  function automatic logic [6:0] pick_pending(input logic [EXC_COUNT-1:0] pend);
    logic [6:0] r;
    r = 7'h00;
    for (int i = EXC_COUNT - 1; i >= ssam_pkg::EXC_FIRST; i--)
    begin
      if (pend[i])
        r = {1'b1, 6'(i)};
    end
    return r;
  endfunction

  // Byte lanes for a size at a byte offset, lane 0 holding the lowest address
  function automatic logic [3:0] lanes_of(input ssam_pkg::ssam_size_e sz,
                                          input logic [1:0] off);
    logic [3:0] l;
    case (sz)
      ssam_pkg::SZ_BYTE: l = 4'(4'h1 << off);
      ssam_pkg::SZ_HALF: l = 4'(4'h3 << off);
      ssam_pkg::SZ_WORD: l = 4'hF;
      default:           l = 4'h0;
    endcase
    return l;
  endfunction

  ssam_addr_decode u_decode
  (
    .i_addr   (i_acc.addr),
    .o_region (region_w),
    .o_xn     (xn_w),
    .o_core   (core_w)
  );

  // Nonzero exception number means Handler mode
  assign handler_w = (state_ff.exc_num != ssam_pkg::EXC_THREAD);
  assign pick_w    = pick_pending(i_exc_pend);

  // Alignment check; private region only takes whole words
  always_comb
  begin
    case (i_acc.size)
      ssam_pkg::SZ_BYTE: misalign_w = 1'b0;
      ssam_pkg::SZ_HALF: misalign_w = i_acc.addr[0];
      ssam_pkg::SZ_WORD: misalign_w = (i_acc.addr[1:0] != 2'h0);
      default:           misalign_w = 1'b1;
    endcase
  end

  assign acc_fault_w = misalign_w ||
                       (region_w == ssam_pkg::REG_PPR && i_acc.size != ssam_pkg::SZ_WORD) ||
                       (i_acc.fetch && xn_w);

  // Read data moved down from its lanes; lowest address is the low byte
  assign shifted_w = i_bus_rdata >> {state_ff.rd_off, 3'b000};

  // Next-state logic for all core state
  always_comb
  begin
    nxt_state          = state_ff;
    nxt_state.take     = 1'b0;
    nxt_state.bus      = '0;
    nxt_state.fault    = 1'b0;
    nxt_state.rd_valid = 1'b0;

    // Return has priority over a new take: the core finishes unstacking first
    if (i_exc_ret.valid && handler_w)
    begin
      nxt_state.exc_num = i_exc_ret.num;
      // Resuming Thread restores its stack choice; a nested handler stays on main
      nxt_state.spsel = (i_exc_ret.num == ssam_pkg::EXC_THREAD) ? i_exc_ret.to_psp
                                                                 : 1'b0;
    end
    else if (i_take_en && pick_w[6] &&
             (!handler_w || pick_w[5:0] < state_ff.exc_num))
    begin
      nxt_state.take      = 1'b1;
      nxt_state.take_num  = pick_w[5:0];
      nxt_state.exc_num   = pick_w[5:0];
      nxt_state.entry_psp = state_ff.spsel;    // Kept for the return code
      nxt_state.spsel     = 1'b0;
    end
    else if (i_sreg.wr && !handler_w)
    begin
      nxt_state.spsel = i_sreg.data[ssam_pkg::CTRL_SPSEL_BIT];
    end
    // Writes while in Handler mode fall through untouched

    // Access request: fault blocks the bus strobe so nothing reaches a slave
    if (i_acc.valid)
    begin
      if (acc_fault_w)
      begin
        nxt_state.fault = 1'b1;
      end
      else
      begin
        nxt_state.bus.valid  = 1'b1;
        nxt_state.bus.write  = i_acc.write;
        nxt_state.bus.core   = core_w;
        nxt_state.bus.region = region_w;
        nxt_state.bus.addr   = i_acc.addr;
        nxt_state.bus.lanes  = lanes_of(i_acc.size, i_acc.addr[1:0]);
        nxt_state.bus.wdata  = i_acc.wdata << {i_acc.addr[1:0], 3'b000};
        nxt_state.rd_off     = i_acc.addr[1:0];
        nxt_state.rd_size    = i_acc.size;
      end
    end

    // Read return: zero-extended, low byte from the lowest address
    if (i_bus_rvalid)
    begin
      nxt_state.rd_valid = 1'b1;
      case (state_ff.rd_size)
        ssam_pkg::SZ_BYTE: nxt_state.rd_data = {24'h000000, shifted_w[7:0]};
        ssam_pkg::SZ_HALF: nxt_state.rd_data = {16'h0000, shifted_w[15:0]};
        default:           nxt_state.rd_data = shifted_w;
      endcase
    end
  end

  // Single state register; reset lands in Thread mode on the main stack
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_ff       <= '0;
      state_ff.spsel <= ssam_pkg::CTRL_SPSEL_RST;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Control read view: bit 1 forced low in Handler mode, other bits reserved zero
  always_comb
  begin
    o_ctrl_rdata = ssam_pkg::CTRL_RESET;
    o_ctrl_rdata[ssam_pkg::CTRL_SPSEL_BIT] = state_ff.spsel && !handler_w;
  end

  // Active pointer choice; Handler mode never selects the process stack
  assign o_use_psp        = state_ff.spsel && !handler_w;
  assign o_handler        = handler_w;
  assign o_exc_num        = state_ff.exc_num;
  assign o_exc_take       = state_ff.take;
  assign o_exc_take_num   = state_ff.take_num;
  assign o_entry_from_psp = state_ff.entry_psp;
  assign o_bus            = state_ff.bus;
  assign o_fault          = state_ff.fault;
  assign o_rd_valid       = state_ff.rd_valid;
  assign o_rd_data        = state_ff.rd_data;

endmodule

// file: ssam_pkg.sv
// Shared constants, enums and carrier structs for the stack select and address map block.
// Assumes a single 100 MHz core clock; all users reference items as ssam_pkg::name.
package ssam_pkg;

  // Stack select control register layout
  localparam int          CTRL_SPSEL_BIT = 1;
  localparam logic        CTRL_SPSEL_RST = 1'b0;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

  // Current exception number field
  localparam int         EXC_NUM_W  = 6;
  localparam logic [5:0] EXC_THREAD = 6'h00;
  localparam int         EXC_FIRST  = 2;
  localparam int         EXC_COUNT  = 48;

  // Fixed region boundaries of the 4GB map
  localparam logic [31:0] SRAM_BASE     = 32'h2000_0000;
  localparam logic [31:0] PERIPH_BASE   = 32'h4000_0000;
  localparam logic [31:0] EXT_RAM_BASE  = 32'h6000_0000;
  localparam logic [31:0] EXT_DEV_BASE  = 32'hA000_0000;
  localparam logic [31:0] PPR_BASE      = 32'hE000_0000;
  localparam logic [31:0] DEVICE_BASE   = 32'hE010_0000;
  // Window inside the private region kept for core peripheral registers
  localparam logic [31:0] PPR_CORE_BASE = 32'hE000_E000;
  localparam logic [31:0] PPR_CORE_END  = 32'hE000_F000;

  typedef enum logic [2:0] {
    REG_CODE    = 3'h0,
    REG_SRAM    = 3'h1,
    REG_PERIPH  = 3'h2,
    REG_EXT_RAM = 3'h3,
    REG_EXT_DEV = 3'h4,
    REG_PPR     = 3'h5,
    REG_DEVICE  = 3'h6
  } ssam_region_e;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2,
    SZ_BAD  = 2'h3
  } ssam_size_e;

  typedef struct packed {
    logic        wr;
    logic [31:0] data;
  } ssam_sreg_s;

  typedef struct packed {
    logic       valid;
    logic [5:0] num;
    logic       to_psp;
  } ssam_ret_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        fetch;
    ssam_size_e  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ssam_acc_s;

  typedef struct packed {
    logic         valid;
    logic         write;
    logic         core;
    ssam_region_e region;
    logic [31:0]  addr;
    logic [3:0]   lanes;
    logic [31:0]  wdata;
  } ssam_bus_s;

endpackage

// file: ssam_addr_decode.sv
// Combinational decoder of the fixed, non-relocatable 32-bit address map.
// Assumes a full byte address; gives region, execute-never and core window flags.
`timescale 1ns/1ps
module ssam_addr_decode
(
  input  wire logic [31:0]           i_addr,
  output ssam_pkg::ssam_region_e     o_region,
  output logic                       o_xn,
  output logic                       o_core
);

  // Region select by ascending base; no programmable remap exists
  always_comb
  begin
    if (i_addr < ssam_pkg::SRAM_BASE)
      o_region = ssam_pkg::REG_CODE;
    else if (i_addr < ssam_pkg::PERIPH_BASE)
      o_region = ssam_pkg::REG_SRAM;
    else if (i_addr < ssam_pkg::EXT_RAM_BASE)
      o_region = ssam_pkg::REG_PERIPH;
    else if (i_addr < ssam_pkg::EXT_DEV_BASE)
      o_region = ssam_pkg::REG_EXT_RAM;
    else if (i_addr < ssam_pkg::PPR_BASE)
      o_region = ssam_pkg::REG_EXT_DEV;
    else if (i_addr < ssam_pkg::DEVICE_BASE)
      o_region = ssam_pkg::REG_PPR;
    else
      o_region = ssam_pkg::REG_DEVICE;
  end

  // Only code, SRAM and external RAM may hold programs
  assign o_xn = !(o_region == ssam_pkg::REG_CODE || o_region == ssam_pkg::REG_SRAM ||
                  o_region == ssam_pkg::REG_EXT_RAM);

  // Core peripheral window carved from the private region
  assign o_core = (i_addr >= ssam_pkg::PPR_CORE_BASE) &&
                  (i_addr < ssam_pkg::PPR_CORE_END);

endmodule

// file: ssam_core_state_assertions.sv
// Checker for the stack select and exception state and the access path.
// Assumes it is bound onto ssam_core_state; one clock, async reset.
`timescale 1ns/1ps
module ssam_chk
#(
  parameter int EXC_COUNT = ssam_pkg::EXC_COUNT
)
(
  input wire logic                 i_ref_clk,
  input wire logic                 i_reset,
  input wire ssam_pkg::ssam_sreg_s i_sreg,
  input wire logic [EXC_COUNT-1:0] i_exc_pend,
  input wire logic                 i_take_en,
  input wire ssam_pkg::ssam_ret_s  i_exc_ret,
  input wire ssam_pkg::ssam_acc_s  i_acc,
  input wire logic [31:0]          o_ctrl_rdata,
  input wire logic                 o_use_psp,
  input wire logic                 o_handler,
  input wire logic [5:0]           o_exc_num,
  input wire logic                 o_exc_take,
  input wire logic [5:0]           o_exc_take_num,
  input wire logic                 o_entry_from_psp,
  input wire ssam_pkg::ssam_bus_s  o_bus,
  input wire logic                 o_fault
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // Steps of a return to Thread and of a take from Thread
  sequence s_thread_ret;
    o_handler && i_exc_ret.valid && i_exc_ret.num == 6'h00;
  endsequence
  sequence s_thread_take;
    !o_handler && i_take_en && (|i_exc_pend[EXC_COUNT-1:2]) && !i_exc_ret.valid;
  endsequence
  handler_rd_zero_a: assert property (o_handler |-> o_ctrl_rdata == 32'h0 && !o_use_psp)
    else $error("handler mode shows process stack");
  // Handler mode is only reached through a take that loads the number
  mode_num_a: assert property ($rose(o_handler)
    |-> o_exc_take && o_exc_num == o_exc_take_num)
    else $error("handler mode entered without a take");
  ctrl_write_a: assert property (i_sreg.wr && !o_handler && !i_take_en && !i_exc_ret.valid
    |=> o_use_psp == $past(i_sreg.data[1]))
    else $error("stack select write lost");
  take_thread_a: assert property (s_thread_take |=> o_exc_take && o_handler)
    else $error("pending exception not taken");
  entry_state_a: assert property (o_exc_take |-> o_exc_num == o_exc_take_num && !o_use_psp
    && o_entry_from_psp == $past(o_use_psp))
    else $error("entry state wrong");
  thread_ret_a: assert property (s_thread_ret |=> !o_handler
    && o_use_psp == $past(i_exc_ret.to_psp))
    else $error("return to thread wrong");
  acc_answer_a: assert property (i_acc.valid |=> o_bus.valid != o_fault)
    else $error("access gave no single answer");
  word_lanes_a: assert property (i_acc.valid && i_acc.write && !i_acc.fetch
    && i_acc.size == ssam_pkg::SZ_WORD && i_acc.addr[1:0] == 2'h0
    |=> o_bus.lanes == 4'hF && o_bus.wdata == $past(i_acc.wdata))
    else $error("word write lanes wrong");
  ppr_word_a: assert property (i_acc.valid && i_acc.addr[31:20] == 12'hE00
    && i_acc.size != ssam_pkg::SZ_WORD |=> o_fault)
    else $error("private region non-word accepted");
  sram_region_a: assert property (o_bus.valid && o_bus.addr[31:29] == 3'h1
    |-> o_bus.region == ssam_pkg::REG_SRAM)
    else $error("sram region code wrong");
endmodule

bind ssam_core_state ssam_chk #(.EXC_COUNT(EXC_COUNT)) u_ssam_chk
(
  .i_ref_clk        (i_ref_clk),
  .i_reset          (i_reset),
  .i_sreg           (i_sreg),
  .i_exc_pend       (i_exc_pend),
  .i_take_en        (i_take_en),
  .i_exc_ret        (i_exc_ret),
  .i_acc            (i_acc),
  .o_ctrl_rdata     (o_ctrl_rdata),
  .o_use_psp        (o_use_psp),
  .o_handler        (o_handler),
  .o_exc_num        (o_exc_num),
  .o_exc_take       (o_exc_take),
  .o_exc_take_num   (o_exc_take_num),
  .o_entry_from_psp (o_entry_from_psp),
  .o_bus            (o_bus),
  .o_fault          (o_fault)
);

// file: testbench.sv
// Self-checking bench: stack select, exception entry and return, access path.
// Assumes the checker file is compiled alongside; one 100 MHz clock.
`timescale 1ns/1ps
module testbench;
  logic clk, rst, ten, rv, process_stack_pointer, hnd, tk, fps, flt, rdv;
  logic [47:0] pend;
  logic [31:0] rdat, ctl, rdd;
  logic [5:0] num, tnum;
  ssam_pkg::ssam_sreg_s sreg;
  ssam_pkg::ssam_ret_s ret;
  ssam_pkg::ssam_acc_s acc;
  ssam_pkg::ssam_bus_s bus;
  int fails, check_count;
  logic [31:0] ra [10] = '{32'h1FFF_FFFC, 32'h2000_0000, 32'h5FFF_FFFC, 32'h6000_0000,
    32'h9FFF_FFFC, 32'hA000_0000, 32'hDFFF_FFFC, 32'hE00F_FFFC, 32'hE010_0000, 32'hFFFF_FFFC};
  logic [2:0] rr [10] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5, 3'h6, 3'h6};
  ssam_core_state #(.EXC_COUNT(48)) u_ssam_core_state (.i_ref_clk(clk), .i_reset(rst),
    .i_sreg(sreg), .i_exc_pend(pend), .i_take_en(ten), .i_exc_ret(ret), .i_acc(acc),
    .i_bus_rvalid(rv), .i_bus_rdata(rdat), .o_ctrl_rdata(ctl), .o_use_psp(process_stack_pointer),
    .o_handler(hnd), .o_exc_num(num), .o_exc_take(tk), .o_exc_take_num(tnum),
    .o_entry_from_psp(fps), .o_bus(bus), .o_fault(flt), .o_rd_valid(rdv), .o_rd_data(rdd));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task end_sim;
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Inputs always change 1 ns after the edge
  task tick;
    @(posedge clk);
    #1;
  endtask
  // Write pulse, then an idle slot so two calls never lower and raise in one step
  task wr_ctl(input logic [31:0] d);
    sreg = '{1'b1, d};
    tick;
    sreg = '0;
    tick; // Idle slot after the write, where software puts its barrier
  endtask
  // Request stays up until the next call or an explicit drop by the caller
  task go(input logic f, input logic w, input ssam_pkg::ssam_size_e s, input logic [31:0] a);
    acc = '{1'b1, w, f, s, a, 32'hABCD};
    tick;
  endtask
  task t_reset;
    chk("ctl", 32'h0, ctl);
    chk("psp", 32'h0, process_stack_pointer);
    chk("num", 32'h0, num);
  endtask
  task t_ctl;
    wr_ctl(32'hFFFF_FFFF);
    chk("ctl", 32'h2, ctl);
    chk("psp", 32'h1, process_stack_pointer);
    wr_ctl(32'hFFFF_FFFD);
    chk("ctl", 32'h0, ctl);
    wr_ctl(32'h2);
  endtask
  task t_exc;
    pend = 48'h8000;
    ten = 1'b1;
    tick;
    pend = 48'h10_0000;
    chk("take", 32'h1, tk);
    chk("tnum", 32'hF, tnum);
    chk("psp", 32'h0, process_stack_pointer);
    chk("from", 32'h1, fps);
    tick;
    chk("take", 32'h0, tk);
    ten = 1'b0;
    pend = 48'h10_0008;
    wr_ctl(32'h2);
    chk("ctl", 32'h0, ctl);
    ten = 1'b1;
    tick;
    ten = 1'b0;
    pend = '0;
    chk("num", 32'h3, num);
    ret = '{1'b1, 6'hF, 1'b0};
    tick;
    ret = '{1'b1, 6'h0, 1'b1};
    chk("num", 32'hF, num);
    tick;
    ret = '0;
    chk("ctl", 32'h2, ctl);
  endtask
  // Reset in mid-run from Handler mode entered while Thread used the process stack
  task t_mid_reset;
    chk("psp", 32'h1, process_stack_pointer);
    pend = 48'h10;
    ten = 1'b1;
    tick;
    ten = 1'b0;
    pend = '0;
    chk("hnd", 32'h1, hnd);
    chk("tnum", 32'h4, tnum);
    rst = 1'b1;
    tick;
    rst = 1'b0;
    chk("hnd", 32'h0, hnd);
    chk("ctl", 32'h0, ctl);
    chk("psp", 32'h0, process_stack_pointer);
    chk("take", 32'h0, tk);
    ret = '{1'b1, 6'hF, 1'b0};
    tick;
    ret = '0;
    chk("num", 32'h0, num);
  endtask
  task t_acc;
    go(1'b0, 1'b1, ssam_pkg::SZ_HALF, 32'h2000_0002);
    chk("valid", 32'h1, bus.valid);
    chk("write", 32'h1, bus.write);
    chk("addr", 32'h2000_0002, bus.addr);
    chk("lanes", 32'hC, bus.lanes);
    chk("wdata", 32'hABCD_0000, bus.wdata);
    go(1'b0, 1'b1, ssam_pkg::SZ_BYTE, 32'h2000_0003);
    chk("lanes", 32'h8, bus.lanes);
    chk("wdata", 32'hCD00_0000, bus.wdata);
    go(1'b0, 1'b1, ssam_pkg::SZ_WORD, 32'h6000_0004);
    chk("lanes", 32'hF, bus.lanes);
    chk("wdata", 32'h0000_ABCD, bus.wdata);
    go(1'b0, 1'b0, ssam_pkg::SZ_BYTE, 32'h2000_0001);
    chk("lanes", 32'h2, bus.lanes);
    chk("write", 32'h0, bus.write);
    rv = 1'b1;
    rdat = 32'h0000_3400;
    acc = '0;
    tick;
    rv = 1'b0;
    chk("rdvalid", 32'h1, rdv);
    chk("rdata", 32'h34, rdd);
    chk("valid", 32'h0, bus.valid);
    go(1'b0, 1'b0, ssam_pkg::SZ_WORD, 32'h2000_0002);
    chk("fault", 32'h1, flt);
    chk("valid", 32'h0, bus.valid);
    go(1'b0, 1'b0, ssam_pkg::SZ_HALF, 32'h2000_0001);
    chk("fault", 32'h1, flt);
    go(1'b0, 1'b0, ssam_pkg::SZ_BAD, 32'h2000_0000);
    chk("fault", 32'h1, flt);
    go(1'b1, 1'b0, ssam_pkg::SZ_WORD, 32'h0000_0100);
    chk("lanes", 32'hF, bus.lanes);
    go(1'b1, 1'b0, ssam_pkg::SZ_WORD, 32'hE000_E010);
    chk("fault", 32'h1, flt);
    go(1'b0, 1'b0, ssam_pkg::SZ_WORD, 32'hE000_E010);
    chk("core", 32'h1, bus.core);
    go(1'b0, 1'b1, ssam_pkg::SZ_HALF, 32'hE000_0000);
    chk("fault", 32'h1, flt);
    for (int i = 0; i < 10; i++)
    begin
      go(1'b0, 1'b0, ssam_pkg::SZ_WORD, ra[i]);
      chk("region", rr[i], bus.region);
    end
    acc = '0;
  endtask
  // Free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Main sequence after five cycles of reset
  initial
  begin
    {rst, ten, rv} = 3'h4;
    {sreg, ret, acc, pend, rdat} = '0;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    t_reset;
    t_ctl;
    t_exc;
    t_mid_reset;
    t_acc;
    end_sim;
  end
  // Bound on the whole run so a hang still reaches the verdict
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    end_sim;
  end
endmodule
